// [spdsi_axil.sv]
`timescale 1ns/10ps
module spdsi_axil #(
   parameter int ADDR_W = 12
) (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] s_axil_awaddr,
   input  wire logic              s_axil_awvalid,
   output logic                   s_axil_awready,
   input  wire logic [31:0]       s_axil_wdata,
   input  wire logic [3:0]        s_axil_wstrb,
   input  wire logic              s_axil_wvalid,
   output logic                   s_axil_wready,
   output logic [1:0]             s_axil_bresp,
   output logic                   s_axil_bvalid,
   input  wire logic              s_axil_bready,
   input  wire logic [ADDR_W-1:0] s_axil_araddr,
   input  wire logic              s_axil_arvalid,
   output logic                   s_axil_arready,
   output logic [31:0]            s_axil_rdata,
   output logic [1:0]             s_axil_rresp,
   output logic                   s_axil_rvalid,
   input  wire logic              s_axil_rready,
   output logic                   wr_en,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic [31:0]            wr_data,
   output logic [3:0]             wr_strb,
   input  wire logic              wr_err,
   output logic                   rd_en,
   output logic [ADDR_W-1:0]      rd_addr,
   input  wire logic [31:0]       rd_data,
   input  wire logic              rd_err
);
   import spdsi_pkg::*;

   logic aw_full_reg;
   logic w_full_reg;

   assign wr_en   = aw_full_reg & w_full_reg & ~s_axil_bvalid;
   assign rd_en   = s_axil_arvalid & s_axil_arready;
   assign rd_addr = s_axil_araddr;

   // ****************************************
   // write channels, taken in either order
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aw_full_reg    <= 1'b0;
         w_full_reg     <= 1'b0;
         s_axil_awready <= 1'b0;
         s_axil_wready  <= 1'b0;
         s_axil_bvalid  <= 1'b0;
         s_axil_bresp   <= RESP_OKAY;
         wr_addr        <= '0;
         wr_data        <= '0;
         wr_strb        <= '0;
      end else begin
         if (s_axil_awvalid && s_axil_awready) begin
            aw_full_reg    <= 1'b1;
            s_axil_awready <= 1'b0;
            wr_addr        <= s_axil_awaddr;
         end else if (wr_en) begin
            aw_full_reg    <= 1'b0;
         end else if (!aw_full_reg) begin
            s_axil_awready <= 1'b1;
         end
         if (s_axil_wvalid && s_axil_wready) begin
            w_full_reg    <= 1'b1;
            s_axil_wready <= 1'b0;
            wr_data       <= s_axil_wdata;
            wr_strb       <= s_axil_wstrb;
         end else if (wr_en) begin
            w_full_reg    <= 1'b0;
         end else if (!w_full_reg) begin
            s_axil_wready <= 1'b1;
         end
         if (wr_en) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid  <= 1'b0;
         s_axil_rdata   <= '0;
         s_axil_rresp   <= RESP_OKAY;
      end else if (rd_en) begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid  <= 1'b1;
         s_axil_rdata   <= rd_data;
         s_axil_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axil_rvalid) begin
         s_axil_rvalid  <= ~s_axil_rready;
      end else begin
         s_axil_arready <= 1'b1;
      end
   end

endmodule : spdsi_axil

// [spdsi_host.sv]
`timescale 1ns/10ps
// ****************************************
// host i/o bus model
// ****************************************
module spdsi_host (
   input  wire logic sys_clk,
   output logic [9:0] io_addr,
   output logic       io_wr_n,
   output logic       io_rd_n
);
   initial begin
      io_addr = 10'h000;
      io_wr_n = 1'b1;
      io_rd_n = 1'b1;
   end
   task automatic io_begin(input logic [9:0] a, input logic wr);
      io_addr <= a;
      repeat (3) @(posedge sys_clk);
      if (wr) io_wr_n <= 1'b0;
      else io_rd_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask : io_begin
   task automatic io_end();
      io_wr_n <= 1'b1;
      io_rd_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      io_addr <= ~io_addr;
      @(posedge sys_clk);
   endtask : io_end
   // write (only when full) then read, arbitrary data, re-arms detection only with the write
   task automatic rearm(input logic full);
      if (full) begin
         io_begin(10'h288, 1'b1);
         io_end();
      end
      io_begin(10'h288, 1'b0);
      io_end();
      repeat (3) @(posedge sys_clk);
   endtask : rearm
endmodule : spdsi_host

// [spdsi_pkg.sv]
// Operation
// RQ1 - switch off: port a 3e8, b 2e8
// RQ2 - switch on: port a 1b0, b 1b8
// RQ3 - line switch off: shared request on 10
// RQ4 - line switch on: shared request on 5
// RQ5 - merge both requests; assist switch selectable
// RQ6 - no assist: request held until all serviced
// RQ7 - assist: re-raise while requests remain pending
// RQ8 - re-arm only on write then read 288
// RQ9 - report 40 mbyte disk from its switch
// RQ10 - select only inside window, pass low bits
package spdsi_pkg;

   // ****************************************
   // io decode
   // ****************************************
   localparam int          IO_ADDR_W        = 10;
   localparam int          WIN_LSB          = 3;
   localparam int          HOST_IRQ_W       = 16;
   localparam logic [9:0]  PORT_A_BASE_STD  = 10'h3e8;
   localparam logic [9:0]  PORT_B_BASE_STD  = 10'h2e8;
   localparam logic [9:0]  PORT_A_BASE_ALT  = 10'h1b0;
   localparam logic [9:0]  PORT_B_BASE_ALT  = 10'h1b8;
   localparam logic [9:0]  REARM_IO_ADDR    = 10'h288;
   localparam logic [3:0]  IRQ_LINE_STD     = 4'ha;
   localparam logic [3:0]  IRQ_LINE_ALT     = 4'h5;

   // ****************************************
   // register map
   // ****************************************
   localparam int          AXI_ADDR_W       = 12;
   localparam logic [11:0] CFG_OFS          = 12'h000;
   localparam logic [11:0] STAT_OFS         = 12'h004;
   localparam logic [11:0] ISTAT_OFS        = 12'h008;
   localparam logic [11:0] IMASK_OFS        = 12'h00c;
   localparam logic [11:0] REARM_OFS        = 12'h288;
   localparam logic [3:0]  CFG_RESET        = 4'h8;
   localparam int          EV_RAISE_BIT     = 0;
   localparam int          EV_REARM_BIT     = 1;
   localparam int          EV_W             = 2;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   typedef struct packed {
      logic       disk_40mb;
      logic       assist_en;
      logic       line_sel;
      logic       win_sel;
   } spdsi_cfg_s;

   typedef struct packed {
      logic [9:0] addr;
      logic       wr;
      logic       rd;
      logic       req_a;
      logic       req_b;
   } spdsi_io_s;

endpackage : spdsi_pkg

// [spdsi_rearm.sv]
`timescale 1ns/10ps
module spdsi_rearm (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic assist_en,
   input  wire logic pending,
   input  wire logic wr_hit,
   input  wire logic rd_hit,
   output logic      shared_req,
   output logic      armed,
   output logic      rearm
);
   import spdsi_pkg::*;

   logic wr_seen_reg;

   assign rearm = rd_hit & (wr_seen_reg | wr_hit);                 // RQ8

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wr_seen_reg <= 1'b0;
         shared_req  <= 1'b0;
         armed       <= 1'b1;
      end else begin
         if (rearm) begin
            wr_seen_reg <= 1'b0;
         end else if (wr_hit) begin
            wr_seen_reg <= 1'b1;
         end
         if (!assist_en) begin
            shared_req <= pending;                                // RQ6
            armed      <= 1'b1;
         end else if (rearm) begin
            shared_req <= 1'b0;                                   // RQ7
            armed      <= 1'b1;
         end else if (armed && pending) begin
            shared_req <= 1'b1;                                   // RQ7
            armed      <= 1'b0;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   chk_assist_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ7
      assist_en && $past(assist_en) && shared_req && !rearm |=> shared_req)
      else $error("shared request dropped without re-arm");

   chk_rearm_gap: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ8
      assist_en && rearm |=> !shared_req ##1 (shared_req == $past(pending)))
      else $error("re-arm did not give a gap and re-raise");

   chk_no_assist: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ6
      !assist_en |=> shared_req == $past(pending))
      else $error("shared request not following pending");

   chk_read_only: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ8
      assist_en && shared_req && rd_hit && !wr_seen_reg && !wr_hit |=> shared_req)
      else $error("re-arm without prior write");

endmodule : spdsi_rearm

// [spdsi_top.sv]
`timescale 1ns/10ps
module spdsi_top #(
   parameter int IO_AW = spdsi_pkg::IO_ADDR_W
) (
   input  wire logic                            sys_clk,
   input  wire logic                            nrst,
   input  wire logic [spdsi_pkg::AXI_ADDR_W-1:0] s_axil_awaddr,
   input  wire logic                            s_axil_awvalid,
   output logic                                 s_axil_awready,
   input  wire logic [31:0]                     s_axil_wdata,
   input  wire logic [3:0]                      s_axil_wstrb,
   input  wire logic                            s_axil_wvalid,
   output logic                                 s_axil_wready,
   output logic [1:0]                           s_axil_bresp,
   output logic                                 s_axil_bvalid,
   input  wire logic                            s_axil_bready,
   input  wire logic [spdsi_pkg::AXI_ADDR_W-1:0] s_axil_araddr,
   input  wire logic                            s_axil_arvalid,
   output logic                                 s_axil_arready,
   output logic [31:0]                          s_axil_rdata,
   output logic [1:0]                           s_axil_rresp,
   output logic                                 s_axil_rvalid,
   input  wire logic                            s_axil_rready,
   input  wire logic [IO_AW-1:0]                io_addr,
   input  wire logic                            io_wr_n,
   input  wire logic                            io_rd_n,
   input  wire logic                            port_a_irq,
   input  wire logic                            port_b_irq,
   output logic                                 port_a_select,
   output logic                                 port_b_select,
   output logic [2:0]                           port_reg_addr,
   output logic [spdsi_pkg::HOST_IRQ_W-1:0]     host_irq,
   output logic                                 disk_40mb_ind,
   output logic                                 irq
);
   import spdsi_pkg::*;

   localparam int SYNC_W = IO_AW + 4;

   if (IO_AW != IO_ADDR_W) begin : g_bad_width
      $error("io address width must equal the decoded width");
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   spdsi_io_s         io_s;

   assign raw_in = {io_addr, ~io_wr_n, ~io_rd_n, port_a_irq, port_b_irq};
   assign io_s   = spdsi_io_s'(sync2_reg);

   for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            sync1_reg[i] <= 1'b0;
            sync2_reg[i] <= 1'b0;
         end else begin
            sync1_reg[i] <= raw_in[i];
            sync2_reg[i] <= sync1_reg[i];
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   spdsi_cfg_s            cfg_reg;
   logic [EV_W-1:0]       istat_reg;
   logic [EV_W-1:0]       istat_next;
   logic [EV_W-1:0]       imask_reg;
   logic                  wr_prev_reg;
   logic                  rd_prev_reg;

   logic                  bus_wr_en;
   logic [AXI_ADDR_W-1:0] bus_wr_addr;
   logic [31:0]           bus_wr_data;
   logic [3:0]            bus_wr_strb;
   logic                  bus_rd_en;
   logic [AXI_ADDR_W-1:0] bus_rd_addr;
   logic [31:0]           bus_rd_data;
   logic                  bus_wr_err;
   logic                  bus_rd_err;

   spdsi_axil #(
      .ADDR_W         (AXI_ADDR_W)
   ) u_axil (
      .sys_clk        (sys_clk),
      .nrst           (nrst),
      .s_axil_awaddr  (s_axil_awaddr),
      .s_axil_awvalid (s_axil_awvalid),
      .s_axil_awready (s_axil_awready),
      .s_axil_wdata   (s_axil_wdata),
      .s_axil_wstrb   (s_axil_wstrb),
      .s_axil_wvalid  (s_axil_wvalid),
      .s_axil_wready  (s_axil_wready),
      .s_axil_bresp   (s_axil_bresp),
      .s_axil_bvalid  (s_axil_bvalid),
      .s_axil_bready  (s_axil_bready),
      .s_axil_araddr  (s_axil_araddr),
      .s_axil_arvalid (s_axil_arvalid),
      .s_axil_arready (s_axil_arready),
      .s_axil_rdata   (s_axil_rdata),
      .s_axil_rresp   (s_axil_rresp),
      .s_axil_rvalid  (s_axil_rvalid),
      .s_axil_rready  (s_axil_rready),
      .wr_en          (bus_wr_en),
      .wr_addr        (bus_wr_addr),
      .wr_data        (bus_wr_data),
      .wr_strb        (bus_wr_strb),
      .wr_err         (bus_wr_err),
      .rd_en          (bus_rd_en),
      .rd_addr        (bus_rd_addr),
      .rd_data        (bus_rd_data),
      .rd_err         (bus_rd_err)
   );

   // ****************************************
   // address decode
   // ****************************************
   logic        wa_cfg;
   logic        wa_istat;
   logic        wa_imask;
   logic        wa_rearm;
   logic        ra_rearm;
   logic        ra_known;
   logic [9:0]  base_a;
   logic [9:0]  base_b;
   logic        io_act;
   logic        hit_a;
   logic        hit_b;
   logic        io_wr_edge;
   logic        io_rd_edge;
   logic        io_at_rearm;
   logic        rearm_wr_hit;
   logic        rearm_rd_hit;

   assign wa_cfg     = bus_wr_en & (bus_wr_addr == CFG_OFS);
   assign wa_istat   = bus_wr_en & (bus_wr_addr == ISTAT_OFS);
   assign wa_imask   = bus_wr_en & (bus_wr_addr == IMASK_OFS);
   assign wa_rearm   = bus_wr_en & (bus_wr_addr == REARM_OFS);
   assign ra_rearm   = bus_rd_en & (bus_rd_addr == REARM_OFS);
   assign ra_known   = (bus_rd_addr == CFG_OFS) | (bus_rd_addr == STAT_OFS) |
                       (bus_rd_addr == ISTAT_OFS) | (bus_rd_addr == IMASK_OFS) |
                       (bus_rd_addr == REARM_OFS);
   assign bus_rd_err = ~ra_known;
   assign bus_wr_err = ~(wa_cfg | wa_istat | wa_imask | wa_rearm |
                         (bus_wr_addr == STAT_OFS));

   assign base_a     = cfg_reg.win_sel ? PORT_A_BASE_ALT : PORT_A_BASE_STD;  // RQ1 RQ2
   assign base_b     = cfg_reg.win_sel ? PORT_B_BASE_ALT : PORT_B_BASE_STD;  // RQ1 RQ2
   assign io_act     = io_s.wr | io_s.rd;
   assign hit_a      = io_s.addr[9:WIN_LSB] == base_a[9:WIN_LSB];           // RQ10
   assign hit_b      = io_s.addr[9:WIN_LSB] == base_b[9:WIN_LSB];           // RQ10
   assign io_wr_edge = io_s.wr & ~wr_prev_reg;
   assign io_rd_edge = io_s.rd & ~rd_prev_reg;
   assign io_at_rearm  = io_s.addr == REARM_IO_ADDR;
   assign rearm_wr_hit = (io_wr_edge & io_at_rearm) | wa_rearm;              // RQ8
   assign rearm_rd_hit = (io_rd_edge & io_at_rearm) | ra_rearm;              // RQ8

   // ****************************************
   // shared request and re-arm
   // ****************************************
   logic pending;
   logic shared_req;
   logic armed;
   logic rearm;
   logic shared_prev_reg;

   assign pending = io_s.req_a | io_s.req_b;                                 // RQ5

   spdsi_rearm u_rearm (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .assist_en  (cfg_reg.assist_en),
      .pending    (pending),
      .wr_hit     (rearm_wr_hit),
      .rd_hit     (rearm_rd_hit),
      .shared_req (shared_req),
      .armed      (armed),
      .rearm      (rearm)
   );

   // ****************************************
   // read mux and event flags
   // ****************************************
   logic [31:0]     stat_word;
   logic [EV_W-1:0] ev_set;

   assign stat_word = {26'h0, armed, shared_req, io_s.req_b, io_s.req_a,
                       port_b_select, port_a_select};
   assign bus_rd_data = (bus_rd_addr == CFG_OFS)   ? {28'h0, cfg_reg} :
                        (bus_rd_addr == STAT_OFS)  ? stat_word :
                        (bus_rd_addr == ISTAT_OFS) ? {30'h0, istat_reg} :
                        (bus_rd_addr == IMASK_OFS) ? {30'h0, imask_reg} :
                        32'h0;

   assign ev_set[EV_RAISE_BIT] = shared_req & ~shared_prev_reg;
   assign ev_set[EV_REARM_BIT] = rearm;
   assign istat_next = (istat_reg & ~({EV_W{wa_istat}} & bus_wr_data[EV_W-1:0])) | ev_set;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_reg         <= spdsi_cfg_s'(CFG_RESET);
         imask_reg       <= '0;
         istat_reg       <= '0;
         irq             <= 1'b0;
         wr_prev_reg     <= 1'b0;
         rd_prev_reg     <= 1'b0;
         shared_prev_reg <= 1'b0;
      end else begin
         if (wa_cfg && bus_wr_strb[0]) begin
            cfg_reg <= spdsi_cfg_s'(bus_wr_data[3:0]);
         end
         if (wa_imask && bus_wr_strb[0]) begin
            imask_reg <= bus_wr_data[EV_W-1:0];
         end
         istat_reg       <= istat_next;
         irq             <= |(istat_next & imask_reg);
         wr_prev_reg     <= io_s.wr;
         rd_prev_reg     <= io_s.rd;
         shared_prev_reg <= shared_req;
      end
   end

   // ****************************************
   // port selects and host lines
   // ****************************************
   logic [HOST_IRQ_W-1:0] line_next;

   for (genvar l = 0; l < HOST_IRQ_W; l++) begin : g_line
      assign line_next[l] = shared_req &
         (l == int'(cfg_reg.line_sel ? IRQ_LINE_ALT : IRQ_LINE_STD));        // RQ3 RQ4
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         port_a_select <= 1'b0;
         port_b_select <= 1'b0;
         port_reg_addr <= 3'h0;
         host_irq      <= '0;
         disk_40mb_ind <= 1'b0;
      end else begin
         port_a_select <= io_act & hit_a;                                   // RQ10
         port_b_select <= io_act & hit_b;                                   // RQ10
         port_reg_addr <= io_s.addr[WIN_LSB-1:0];                           // RQ10
         host_irq      <= line_next;
         disk_40mb_ind <= cfg_reg.disk_40mb;                                // RQ9
      end
   end

   // ****************************************
   // checks
   // ****************************************
   chk_win_std_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ1
      io_act && !cfg_reg.win_sel && io_s.addr[9:3] == 7'h7d |=> port_a_select && !port_b_select)
      else $error("standard window a not selected");

   chk_win_std_b: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ1
      io_act && !cfg_reg.win_sel && io_s.addr[9:3] == 7'h5d |=> port_b_select && !port_a_select)
      else $error("standard window b not selected");

   chk_win_alt: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ2
      io_act && cfg_reg.win_sel && io_s.addr[9:4] == 6'h1b |=> (port_a_select ^ port_b_select) &&
      port_b_select == $past(io_s.addr[3]))
      else $error("alternate windows not selected");

   chk_line_std: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ3
      shared_req && !cfg_reg.line_sel |=> host_irq == 16'h0400)
      else $error("shared request not on line 10");

   chk_line_alt: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ4
      shared_req && cfg_reg.line_sel |=> host_irq == 16'h0020)
      else $error("shared request not on line 5");

   chk_merge_req: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ5
      !cfg_reg.assist_en && $stable(cfg_reg) && io_s.req_b |=> ##1 |host_irq)
      else $error("port b request not merged onto host line");

   chk_disk_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ9
      $past(nrst) |-> disk_40mb_ind == $past(cfg_reg.disk_40mb))
      else $error("disk capacity flag not reported");

   chk_sel_window: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ10
      port_a_select |-> $past(io_act) && $past(hit_a) && port_reg_addr == $past(io_s.addr[2:0]))
      else $error("port select outside window");

   chk_sel_idle: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ10
      !io_act |=> !port_a_select && !port_b_select)
      else $error("port select without strobe");

   chk_line_idle: assert property (@(posedge sys_clk) disable iff (!nrst) // RQ5
      !shared_req |=> host_irq == 16'h0000)
      else $error("host line raised without shared request");

endmodule : spdsi_top

// [testbench.sv]
`timescale 1ns/10ps
// ****************************************
// testbench
// ****************************************
module testbench;
   import spdsi_pkg::*;
   logic        sys_clk, nrst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd, rdv;
   logic [1:0]  bresp, rresp, resp;
   logic [3:0]  ws;
   logic        io_wr_n, io_rd_n, rq_a, rq_b, sel_a, sel_b, disk, irq;
   logic [9:0]  io_addr;
   logic [2:0]  rga;
   logic [15:0] hirq;
   int          fail_count, comparisons;
   logic [12:0] rows [6] = '{{1'b0,10'h3e8,2'b10}, {1'b0,10'h2ef,2'b01}, {1'b0,10'h3f0,2'b00},
                             {1'b1,10'h1b0,2'b10}, {1'b1,10'h1bf,2'b01}, {1'b1,10'h3ef,2'b00}};
   spdsi_top DUT (.sys_clk(sys_clk), .nrst(nrst), .s_axil_awaddr(awa), .s_axil_awvalid(awv),
      .s_axil_awready(awr), .s_axil_wdata(wd), .s_axil_wstrb(ws), .s_axil_wvalid(wv),
      .s_axil_wready(wr), .s_axil_bresp(bresp), .s_axil_bvalid(bv), .s_axil_bready(br),
      .s_axil_araddr(ara), .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rd),
      .s_axil_rresp(rresp), .s_axil_rvalid(rv), .s_axil_rready(rr), .io_addr(io_addr),
      .io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .port_a_irq(rq_a), .port_b_irq(rq_b),
      .port_a_select(sel_a), .port_b_select(sel_b), .port_reg_addr(rga), .host_irq(hirq),
      .disk_40mb_ind(disk), .irq(irq));
   spdsi_host host (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      repeat (2) @(posedge sys_clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (!done) begin
         @(posedge sys_clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (bv) begin
            resp = bresp;
            br <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axw
   task automatic axr(input logic [11:0] a, output logic [1:0] r, output logic [31:0] d);
      logic done;
      done = 1'b0;
      repeat (2) @(posedge sys_clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      while (!done) begin
         @(posedge sys_clk);
         if (arv && arr) arv <= 1'b0;
         if (rv) begin
            r = rresp;
            d = rd;
            rr <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axr
   task automatic reqs(input logic a, input logic b);
      rq_a <= a;
      rq_b <= b;
      repeat (8) @(posedge sys_clk);
   endtask : reqs
   task automatic summarize();
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #3000000;
      fail_count++;
      summarize();
   end
   initial begin
      {nrst, awv, wv, br, arv, rr, rq_a, rq_b} = '0;
      awa = '0;
      ara = '0;
      wd = '0;
      ws = 4'hf;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(disk, 1'b1, "disk size report");
      chk(hirq, 16'h0, "idle host lines");
      foreach (rows[i]) begin
         axw(CFG_OFS, {31'h4, rows[i][12]});
         host.io_begin(rows[i][11:2], i[0]);
         chk({sel_a, sel_b}, rows[i][1:0], "window decode");
         chk(rga, rows[i][4:2], "low address bits");
         host.io_end();
         chk({sel_a, sel_b}, 2'b00, "select after strobe");
      end
      ws <= 4'h0;
      axw(CFG_OFS, 32'h0);
      ws <= 4'hf;
      axr(CFG_OFS, resp, rdv);
      chk(rdv, 32'h9, "write without lane 0");
      axw(IMASK_OFS, 32'h1);
      axw(CFG_OFS, 32'h8);
      reqs(1'b1, 1'b0);
      chk(hirq, 16'h0400, "shared on line 10");
      chk(irq, 1'b1, "raise event");
      reqs(1'b1, 1'b1);
      axw(CFG_OFS, 32'ha);
      repeat (4) @(posedge sys_clk);
      chk(hirq, 16'h0020, "shared on line 5");
      axw(ISTAT_OFS, 32'h3);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0, "event cleared");
      axr(12'h010, resp, rdv);
      chk(resp, RESP_SLVERR, "unmapped read");
      chk(rdv, 32'h0, "unmapped read data");
      axw(12'h010, 32'h0);
      chk(resp, RESP_SLVERR, "unmapped write");
      reqs(1'b0, 1'b0);
      axw(CFG_OFS, 32'hc);
      host.rearm(1'b1);
      reqs(1'b0, 1'b1);
      chk(hirq, 16'h0400, "assist raise");
      reqs(1'b0, 1'b0);
      chk(hirq, 16'h0400, "held until re-arm");
      axr(STAT_OFS, resp, rdv);
      chk(rdv, 32'h10, "status while held");
      host.rearm(1'b0);
      chk(hirq, 16'h0400, "read alone ignored");
      host.rearm(1'b1);
      chk(hirq, 16'h0, "re-arm with none pending");
      reqs(1'b1, 1'b1);
      axw(ISTAT_OFS, 32'h3);
      host.rearm(1'b1);
      chk(irq, 1'b1, "re-raise event");
      chk(hirq, 16'h0400, "re-raise while pending");
      reqs(1'b0, 1'b0);
      host.rearm(1'b1);
      chk(hirq, 16'h0, "all serviced");
      reqs(1'b1, 1'b0);
      reqs(1'b0, 1'b0);
      chk(hirq, 16'h0400, "held before bus re-arm");
      axw(REARM_OFS, 32'h0);
      axr(REARM_OFS, resp, rdv);
      chk(resp, RESP_OKAY, "re-arm read response");
      repeat (2) @(posedge sys_clk);
      chk(hirq, 16'h0, "bus re-arm");
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0, "irq in reset");
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      axr(CFG_OFS, resp, rdv);
      chk(rdv, {28'h0, CFG_RESET}, "cfg after reset");
      summarize();
   end
endmodule : testbench
